// File: src/port_function_mux.sv
// pin-function multiplexer for ports a, b, e, f and g
//
// Local design decisions: the register addresses and the strobed register port.
module port_function_mux
    import port_mux_pkg::*;
#(
    parameter int PIN_W = PW
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NPORT-1:0][PW-1:0] pin_in,
    output pin_drive_t [NPORT-1:0] pin_drive,
    input wire logic [NPORT-1:0][PW-1:0] pld_out,
    output logic [NPORT-1:0][PW-1:0] pld_in,
    input wire logic [PW-1:0] addr_latched,
    output logic [ADDR_IN_W-1:0] addr_in_low,
    input wire logic [PW-1:0] bus_rd_data,
    input wire logic bus_rd_en,
    output logic [PW-1:0] bus_wr_data,
    output jtag_in_t jtag_pins,
    input wire logic jtag_tdo,
    input wire logic isp_status_signal,
    input wire logic isp_error_n,
    input wire logic ready_busy
);

    if (PIN_W != PW) begin : g_bad_width
        $error("port_function_mux serves eight-bit ports only");
    end

    logic [NPORT-1:0][PW-1:0] sync_lvl;
    logic [NPORT-1:0][PW-1:0] dout_q, dout_d, dir_q, dir_d;
    logic [NPORT-1:0][PW-1:0] ctrl_q, ctrl_d, pld_q, pld_d;
    logic jtag_en_q, jtag_en_d;
    logic [MODE_W-1:0] mode_q, mode_d;
    logic [7:0] rdata_q, rdata_d;
    pin_drive_t [NPORT-1:0] drive_q, drive_d;
    pin_fn_t [NPORT-1:0][PW-1:0] fn;
    jtag_in_t jtag_q, jtag_d;
    logic [ADDR_IN_W-1:0] addr_in_q, addr_in_d;
    logic [PW-1:0] bus_wr_q, bus_wr_d;
    lane_t lane;

    level_sync #(.WIDTH(NPORT * PW), .STAGES(2)) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(sync_lvl)
    );

    assign lane = lane_t'(mode_q[MODE_LANE_LSB +: MODE_LANE_W]);

    function automatic logic lane_hits(lane_t l, int p);
        return (l == LANE_F && p == PF) || (l == LANE_G && p == PG) ||
            (l == LANE_A && p == PA) || (l == LANE_B && p == PB);
    endfunction

    // priority: programming port, data lane, address in, address out,
    // logic, then plain mcu i/o
    function automatic pin_fn_t pin_fn(int p, int b, logic jt, lane_t l,
        logic xa, logic ctrl, logic programmable_logic);
        if (p == PE && jt && b <= JT_ERR) begin
            return (b >= JT_TDO) ? FN_JTAG_OUT : FN_JTAG_IN;
        end
        if (lane_hits(l, p)) begin
            return FN_DATA;
        end
        if (p == PF && xa && b < ADDR_IN_W) begin
            return FN_ADDR_IN;
        end
        if (ctrl) begin
            return FN_ADDR_OUT;
        end
        if (programmable_logic) begin
            return FN_PLD;
        end
        return FN_MCU;
    endfunction

    always_comb begin
        dout_d = dout_q;
        dir_d = dir_q;
        ctrl_d = ctrl_q;
        pld_d = pld_q;
        jtag_en_d = jtag_en_q;
        mode_d = mode_q;
        rdata_d = 8'h00;
        if (reg_wr) begin
            for (int p = 0; p < NPORT; p++) begin
                if (reg_addr == OFF_DOUT[p]) begin
                    dout_d[p] = reg_wdata;
                end
                if (reg_addr == OFF_DIR[p]) begin
                    dir_d[p] = reg_wdata;
                end
                if (HAS_CTRL[p] && reg_addr == OFF_CTRL[p]) begin
                    ctrl_d[p] = reg_wdata;
                end
                if (reg_addr == OFF_PLD[p]) begin
                    pld_d[p] = reg_wdata;
                end
            end
            if (reg_addr == OFF_JTAG_EN) begin
                jtag_en_d = reg_wdata[JTAG_EN_BIT];
            end
            if (reg_addr == OFF_MODE) begin
                mode_d = reg_wdata[MODE_W-1:0];
            end
        end
        if (reg_rd) begin
            for (int p = 0; p < NPORT; p++) begin
                if (reg_addr == OFF_DIN[p]) begin
                    rdata_d = sync_lvl[p];
                end
                if (reg_addr == OFF_DOUT[p]) begin
                    rdata_d = dout_q[p];
                end
                if (reg_addr == OFF_DIR[p]) begin
                    rdata_d = dir_q[p];
                end
                if (HAS_CTRL[p] && reg_addr == OFF_CTRL[p]) begin
                    rdata_d = ctrl_q[p];
                end
                if (reg_addr == OFF_PLD[p]) begin
                    rdata_d = pld_q[p];
                end
            end
            if (reg_addr == OFF_JTAG_EN) begin
                rdata_d = {7'h00, jtag_en_q};
            end
            if (reg_addr == OFF_MODE) begin
                rdata_d = {3'h0, mode_q};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dout_q <= '0;
            dir_q <= '0;
            ctrl_q <= '0;
            pld_q <= '0;
            jtag_en_q <= JTAG_EN_RST;
            mode_q <= MODE_RST;
            rdata_q <= 8'h00;
        end else begin
            dout_q <= dout_d;
            dir_q <= dir_d;
            ctrl_q <= ctrl_d;
            pld_q <= pld_d;
            jtag_en_q <= jtag_en_d;
            mode_q <= mode_d;
            rdata_q <= rdata_d;
        end
    end

    for (genvar p = 0; p < NPORT; p++) begin : g_port
        for (genvar b = 0; b < PW; b++) begin : g_bit
            logic o, dr;
            assign fn[p][b] = pin_fn(p, b, jtag_en_q, lane,
                mode_q[MODE_ADDR_IN_BIT], HAS_CTRL[p] & ctrl_q[p][b],
                pld_q[p][b]);
            always_comb begin
                o = 1'b0;
                dr = 1'b0;
                unique case (fn[p][b])
                    FN_MCU: begin
                        o = dout_q[p][b];
                        dr = dir_q[p][b];
                    end
                    FN_PLD: begin
                        o = pld_out[p][b];
                        dr = dir_q[p][b];
                    end
                    FN_ADDR_OUT: begin
                        o = addr_latched[b];
                        dr = 1'b1;
                    end
                    FN_ADDR_IN, FN_JTAG_IN: begin
                        o = 1'b0;
                        dr = 1'b0;
                    end
                    FN_DATA: begin
                        o = bus_rd_data[b];
                        dr = bus_rd_en;
                    end
                    FN_JTAG_OUT: begin
                        dr = 1'b1;
                        if (b == JT_TDO) begin
                            o = jtag_tdo;
                        end else if (b == JT_STAT) begin
                            o = mode_q[MODE_RB_BIT] ? ready_busy
                                : isp_status_signal;
                        end else begin
                            o = isp_error_n;
                        end
                    end
                endcase
                drive_d[p].out[b] = o;
                drive_d[p].oe_n[b] = ~dr;
            end
        end
    end

    always_comb begin
        jtag_d = '0;
        if (jtag_en_q) begin
            jtag_d.tms = sync_lvl[PE][JT_TMS];
            jtag_d.tck = sync_lvl[PE][JT_TCK];
            jtag_d.tdi = sync_lvl[PE][JT_TDI];
        end
        addr_in_d = mode_q[MODE_ADDR_IN_BIT]
            ? sync_lvl[PF][ADDR_IN_W-1:0] : '0;
        bus_wr_d = 8'h00;
        for (int p = 0; p < NPORT; p++) begin
            if (lane_hits(lane, p)) begin
                bus_wr_d = sync_lvl[p];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            drive_q <= {NPORT{pin_drive_t'({PORT_RST, 8'hff})}};
            jtag_q <= '0;
            addr_in_q <= '0;
            bus_wr_q <= 8'h00;
        end else begin
            drive_q <= drive_d;
            jtag_q <= jtag_d;
            addr_in_q <= addr_in_d;
            bus_wr_q <= bus_wr_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign pin_drive = drive_q;
    assign pld_in = sync_lvl;
    assign jtag_pins = jtag_q;
    assign addr_in_low = addr_in_q;
    assign bus_wr_data = bus_wr_q;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    tdo_on_pin_a: assert property (
        jtag_en_q |=> !pin_drive[PE].oe_n[JT_TDO] &&
            pin_drive[PE].out[JT_TDO] == $past(jtag_tdo))
        else $error("tdo not driven on port e pin 3");
    tms_forward_a: assert property (
        jtag_en_q |=> jtag_pins.tms == $past(sync_lvl[PE][JT_TMS]) &&
            pin_drive[PE].oe_n[JT_TCK])
        else $error("tms not forwarded or tck pin driven");
    error_level_a: assert property (
        jtag_en_q |=> pin_drive[PE].out[JT_ERR] == $past(isp_error_n))
        else $error("error pin level differs from error input");
    ready_busy_a: assert property (
        jtag_en_q && mode_q[MODE_RB_BIT] |=>
            pin_drive[PE].out[JT_STAT] == $past(ready_busy))
        else $error("ready/busy not shown on port e pin 4");
    pld_route_a: assert property (
        fn[PA][0] == FN_PLD |=> pin_drive[PA].out[0] == $past(pld_out[PA][0]))
        else $error("logic output not routed to pin");
    read_level_a: assert property (
        reg_rd && reg_addr == OFF_DIN[PG] |=>
            reg_rdata == $past(sync_lvl[PG]))
        else $error("read of port g level wrong");
    addr_in_a: assert property (
        mode_q[MODE_ADDR_IN_BIT] ##1 mode_q[MODE_ADDR_IN_BIT] |->
            addr_in_low == $past(sync_lvl[PF][ADDR_IN_W-1:0]) &&
            pin_drive[PF].oe_n[ADDR_IN_W-1:0] == 4'hf)
        else $error("port f low address inputs wrong");
    lane_f_a: assert property (
        lane == LANE_F && bus_rd_en |=> pin_drive[PF].oe_n == 8'h00 &&
            pin_drive[PF].out == $past(bus_rd_data))
        else $error("port f data lane not driven");
    lane_a_a: assert property (
        lane == LANE_A |=> bus_wr_data == $past(sync_lvl[PA]))
        else $error("port a data lane not sampled");
    addr_out_a: assert property (
        fn[PG][7] == FN_ADDR_OUT |=> !pin_drive[PG].oe_n[7] &&
            pin_drive[PG].out[7] == $past(addr_latched[7]))
        else $error("latched address not on port g");
    fallback_a: assert property (
        !jtag_en_q && fn[PE][JT_TMS] == FN_MCU |=>
            pin_drive[PE].out[JT_TMS] == $past(dout_q[PE][JT_TMS]) &&
            pin_drive[PE].oe_n[JT_TMS] == !$past(dir_q[PE][JT_TMS]))
        else $error("port e pin 0 ignores its configuration");

endmodule

// File: common/port_mux_pkg.sv
// shared constants and types for the port pin-function multiplexer
package port_mux_pkg;

    localparam int NPORT = 5;
    localparam int PW = 8;

    // port index order used by every per-port array
    localparam int PA = 0;
    localparam int PB = 1;
    localparam int PE = 2;
    localparam int PF = 3;
    localparam int PG = 4;

    typedef logic [7:0] reg_addr_t;

    localparam reg_addr_t OFF_DIN [NPORT] =
        '{8'h00, 8'h01, 8'h30, 8'h40, 8'h41};
    localparam reg_addr_t OFF_DOUT [NPORT] =
        '{8'h04, 8'h05, 8'h34, 8'h44, 8'h45};
    localparam reg_addr_t OFF_DIR [NPORT] =
        '{8'h06, 8'h07, 8'h36, 8'h46, 8'h47};
    // ports a and b have no control register
    localparam reg_addr_t OFF_CTRL [NPORT] =
        '{8'h00, 8'h00, 8'h32, 8'h42, 8'h43};
    localparam logic [NPORT-1:0] HAS_CTRL = 5'h1c;
    localparam reg_addr_t OFF_PLD [NPORT] =
        '{8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4};
    localparam reg_addr_t OFF_JTAG_EN = 8'hc7;
    localparam reg_addr_t OFF_MODE = 8'hc8;

    // bus mode register fields
    localparam int MODE_ADDR_IN_BIT = 0;
    localparam int MODE_LANE_LSB = 1;
    localparam int MODE_LANE_W = 3;
    localparam int MODE_RB_BIT = 4;
    localparam int MODE_W = 5;
    localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
    localparam int JTAG_EN_BIT = 0;
    localparam logic JTAG_EN_RST = 1'b0;
    localparam logic [PW-1:0] PORT_RST = 8'h00;

    // serial programming pins on port e
    localparam int JT_TMS = 0;
    localparam int JT_TCK = 1;
    localparam int JT_TDI = 2;
    localparam int JT_TDO = 3;
    localparam int JT_STAT = 4;
    localparam int JT_ERR = 5;
    localparam int ADDR_IN_W = 4;

    typedef enum logic [2:0] {
        LANE_NONE,
        LANE_F,
        LANE_G,
        LANE_A,
        LANE_B
    } lane_t;

    typedef enum logic [2:0] {
        FN_MCU,
        FN_PLD,
        FN_ADDR_OUT,
        FN_ADDR_IN,
        FN_DATA,
        FN_JTAG_IN,
        FN_JTAG_OUT
    } pin_fn_t;

    typedef struct packed {
        logic [PW-1:0] out;
        logic [PW-1:0] oe_n;
    } pin_drive_t;

    typedef struct packed {
        logic tms;
        logic tck;
        logic tdi;
    } jtag_in_t;

endpackage

// File: src/level_sync.sv
// two-stage synchroniser for a vector of asynchronous pin levels
module level_sync #(
    parameter int WIDTH = 8,
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    if (STAGES < 2) begin : g_bad_stages
        $error("level_sync needs at least two stages");
    end

    logic [STAGES-1:0][WIDTH-1:0] chain_q;
    logic [STAGES-1:0][WIDTH-1:0] chain_d;

    // stage 0 is read only by stage 1
    always_comb begin
        chain_d = {chain_q[STAGES-2:0], async_in};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            chain_q <= '0;
        end else begin
            chain_q <= chain_d;
        end
    end

    assign sync_out = chain_q[STAGES-1];

endmodule

// File: verif/pin_world.sv
// far-side pin model: external drivers and released pin levels
module pin_world
    import port_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire pin_drive_t [NPORT-1:0] pin_drive,
    input wire logic [NPORT-1:0][PW-1:0] ext_val,
    input wire logic [NPORT-1:0][PW-1:0] ext_en,
    output logic [NPORT-1:0][PW-1:0] pin_in,
    output logic adapter_error
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [NPORT-1:0][PW-1:0] last_q, known, lvl;
    // last level that anyone drove; held while nobody drives
    always_ff @(posedge clk) begin
        last_q <= rst ? '0 : (known & lvl) | (~known & last_q);
    end
    // undriven pins float: inverse of last level, never a stale match
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            for (int b = 0; b < PW; b++) begin
                known[p][b] = !pin_drive[p].oe_n[b] || ext_en[p][b];
                lvl[p][b] = !pin_drive[p].oe_n[b] ? pin_drive[p].out[b]
                    : ext_val[p][b];
                pin_in[p][b] = known[p][b] ? lvl[p][b] : ~last_q[p][b];
            end
        end
    end
    assign adapter_error = ~pin_in[PE][JT_ERR];
endmodule

// File: verif/tb_top.sv
// self-checking bench for the port pin-function multiplexer
module tb_top
    import port_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, reg_wr, reg_rd, bus_rd_en, jtag_tdo;
    logic isp_status_signal, isp_error_n, ready_busy, adapter_error;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, addr_latched, bus_rd_data;
    logic [7:0] bus_wr_data, v, w;
    logic [ADDR_IN_W-1:0] addr_in_low;
    logic [NPORT-1:0][PW-1:0] pin_in, pld_out, pld_in, ext_val, ext_en;
    pin_drive_t [NPORT-1:0] pin_drive;
    jtag_in_t jtag_pins;
    logic [15:0] x;
    int n_fail, checks, seed, q;

    port_function_mux u_port_function_mux (.clk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_drive,
        .pld_out, .pld_in, .addr_latched, .addr_in_low, .bus_rd_data,
        .bus_rd_en, .bus_wr_data, .jtag_pins, .jtag_tdo,
        .isp_status_signal, .isp_error_n, .ready_busy);
    pin_world u_pin_world (.clk, .rst, .pin_drive, .ext_val, .ext_en,
        .pin_in, .adapter_error);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input reg_addr_t a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands one cycle only, so sample at that single edge
    task automatic rd(input reg_addr_t a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask

    // covers the two-flop pin synchroniser plus the output register
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask

    function automatic int lane_port(input int lane);
        case (lane)
            1: return PF;
            2: return PG;
            3: return PA;
            default: return PB;
        endcase
    endfunction

    // port e drive with pins 0-2 released; data-out byte is 8'ha5
    function automatic logic [15:0] jtag_exp(input logic [7:0] d,
        input logic err, input logic rb);
        return {3'h0, 2'b10, err, rb ? ~d[4] : d[4], d[3], 8'h07};
    endfunction

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // about 400 cycles expected; generous margin
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report;
    end

    initial begin
        seed = 18577;
        n_fail = 0;
        checks = 0;
        rst = 1'b1;
        {reg_wr, reg_rd, bus_rd_en, jtag_tdo} = 4'h0;
        {isp_status_signal, isp_error_n, ready_busy} = 3'h2;
        {reg_addr, reg_wdata, addr_latched, bus_rd_data} = '0;
        pld_out = '0;
        ext_val = '0;
        ext_en = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            chk(pin_drive[p].oe_n, 8'hff);
            rd(OFF_DIR[p], v);
            chk(v, 8'h00);
            if (HAS_CTRL[p]) begin
                rd(OFF_CTRL[p], v);
                chk(v, 8'h00);
            end
        end
        wr(8'hfe, 8'h5a);
        rd(8'hfe, v);
        chk(v, 8'h00);
        rd(OFF_JTAG_EN, v);
        chk(v, 8'h00);
        $display("test reset done");
        for (int p = 0; p < NPORT; p++) begin
            v = 8'($random(seed));
            w = 8'($random(seed));
            wr(OFF_DIR[p], 8'hff);
            wr(OFF_DOUT[p], v);
            settle();
            chk(pin_drive[p], {v, 8'h00});
            rd(OFF_DOUT[p], x[7:0]);
            chk(x[7:0], v);
            wr(OFF_DIR[p], 8'h00);
            ext_val[p] <= w;
            ext_en[p] <= 8'hff;
            wr(OFF_DIN[p], ~w);
            settle();
            rd(OFF_DIN[p], v);
            chk(v, w);
        end
        $display("test mcu io done");
        for (int p = PE; p <= PG; p++) begin
            addr_latched <= 8'($random(seed));
            wr(OFF_CTRL[p], 8'h8f);
            settle();
            x = {3'h0, pin_drive[p].out[7], pin_drive[p].out[3:0],
                pin_drive[p].oe_n};
            chk(x, {3'h0, addr_latched[7], addr_latched[3:0], 8'h70});
            wr(OFF_CTRL[p], 8'h00);
        end
        $display("test address out done");
        for (int p = 0; p < NPORT; p++) begin
            pld_out[p] <= 8'($random(seed));
            ext_val[p] <= 8'($random(seed));
            wr(OFF_PLD[p], 8'hff);
            wr(OFF_DIR[p], 8'hf0);
            settle();
            x = {4'h0, pin_drive[p].out[7:4], pin_drive[p].oe_n};
            chk(x, {pld_out[p][7:4], 8'h0f});
            chk(pld_in[p], {pld_out[p][7:4], ext_val[p][3:0]});
            wr(OFF_PLD[p], 8'h00);
            wr(OFF_DIR[p], 8'h00);
        end
        $display("test logic io done");
        ext_val[PF] <= 8'($random(seed));
        wr(OFF_MODE, 8'h01);
        settle();
        chk(addr_in_low, ext_val[PF][3:0]);
        wr(OFF_MODE, 8'h00);
        $display("test address in done");
        for (int l = 1; l <= 4; l++) begin
            q = lane_port(l);
            bus_rd_data <= 8'($random(seed));
            bus_rd_en <= 1'b1;
            wr(OFF_MODE, 8'(l << 1));
            settle();
            chk(pin_drive[q], {bus_rd_data, 8'h00});
            bus_rd_en <= 1'b0;
            ext_val[q] <= 8'($random(seed));
            settle();
            chk(bus_wr_data, ext_val[q]);
        end
        // lane code 5 selects no port at all
        wr(OFF_MODE, 8'h0a);
        settle();
        chk(bus_wr_data, 8'h00);
        wr(OFF_MODE, 8'h00);
        $display("test data lanes done");
        wr(OFF_DIR[PE], 8'hff);
        wr(OFF_DOUT[PE], 8'ha5);
        wr(OFF_JTAG_EN, 8'h01);
        for (int k = 0; k < 4; k++) begin
            v = 8'($random(seed));
            ext_val[PE] <= v;
            jtag_tdo <= v[3];
            isp_status_signal <= v[4];
            ready_busy <= ~v[4];
            isp_error_n <= k[0];
            wr(OFF_MODE, {3'h0, k[1], 4'h0});
            settle();
            chk(jtag_pins, {v[0], v[1], v[2]});
            x = {3'h0, pin_drive[PE].out[7:3], pin_drive[PE].oe_n};
            chk(x, jtag_exp(v, k[0], k[1]));
            chk(adapter_error, {15'h0000, ~k[0]});
        end
        wr(OFF_JTAG_EN, 8'h00);
        wr(OFF_MODE, 8'h00);
        settle();
        chk(pin_drive[PE], {8'ha5, 8'h00});
        chk(jtag_pins, 3'h0);
        $display("test serial port done");
        final_report;
    end
endmodule
